//--- hdl/urlc_pkg.sv
package urlc_pkg;

  // register byte addresses, one aligned word each
  localparam logic [31:0] ADDR_TX_DATA = 32'h4000_4000;
  localparam logic [31:0] ADDR_TX_STATUS = 32'h4000_4004;
  localparam logic [31:0] ADDR_TX_IRQ_EN = 32'h4000_4008;
  localparam logic [31:0] ADDR_RX_POP = 32'h4000_4010;
  localparam logic [31:0] ADDR_RX_FLAGS = 32'h4000_4014;
  localparam logic [31:0] ADDR_RX_IRQ_EN = 32'h4000_4018;
  localparam logic [31:0] ADDR_RX_IDLE_LIMIT = 32'h4000_401C;
  localparam logic [31:0] ADDR_LINE_SETUP = 32'h4000_4020;

  // reset values
  localparam logic [7:0] RST_IDLE_LIMIT = 8'hFF;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [5:0] RST_LINE_SETUP = 6'h00;

  // receive condition flag positions
  localparam int RXF_STOP_MISSING = 7;
  localparam int RXF_OVERRUN = 6;
  localparam int RXF_PARITY = 5;
  localparam int RXF_TIMEOUT = 4;

  // parity mode encodings
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_SPACE = 2'h2;
  localparam logic [1:0] PAR_MARK = 2'h3;

  // fifo geometry and fill thresholds
  localparam int PTR_W = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] LVL_QUARTER = 5'h04;
  localparam logic [4:0] LVL_HALF = 5'h08;
  localparam logic [4:0] LVL_THREE_Q = 5'h0C;

  // line timing: fixed bit rate, divider register is out of scope
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam logic [7:0] BIT_CYC = 8'(CLK_HZ / BAUD_RATE);
  localparam logic [7:0] HALF_BIT_CYC = 8'(CLK_HZ / BAUD_RATE / 2);

  // line format setup field layout, low six bits of the register
  typedef struct packed {
    logic cts_en;       // bit 5
    logic stop_two;     // bit 4
    logic [1:0] par_mode; // bits 3:2
    logic par_en;       // bit 1
    logic char_length_sel; // bit 0, 1 = seven bits
  } urlc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100,
    ST_STOP2 = 3'b101
  } urlc_state_t;

endpackage

//--- hdl/urlc_top.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module urlc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_n_i,
  output logic rx_irq_o,
  output logic tx_irq_o
);

  // ---------------- registers and state ----------------
  urlc_pkg::urlc_cfg_t cfg_q;
  logic [7:0] rx_irq_en_q;
  logic [5:0] tx_irq_en_q;
  logic [7:0] idle_limit_q;
  logic [3:0] rx_sticky_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [1:0] rxd_sync_q;
  logic [1:0] cts_sync_q;

  logic [7:0] rx_mem_q [16];
  logic [7:0] tx_mem_q [16];
  logic [4:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;

  urlc_pkg::urlc_state_t rx_st_q;
  logic [7:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q;
  logic rx_done_q;
  logic rx_frame_bad_q;
  logic rx_par_bad_q;

  urlc_pkg::urlc_state_t tx_st_q;
  logic [7:0] tx_cnt_q;
  logic [2:0] tx_idx_q;
  logic [7:0] tx_sh_q;

  logic [7:0] tmo_pre_q;
  logic [7:0] tmo_cnt_q;
  logic tmo_hit_q;

  // ---------------- bus decode ----------------
  wire addr_phase = hsel_i & hready_i & htrans_i[1];
  wire rd_en = addr_phase & ~hwrite_i;
  wire [4:0] rx_count = rx_wp_q - rx_rp_q;
  wire [4:0] tx_count = tx_wp_q - tx_rp_q;
  wire rx_empty = (rx_count == 5'h00);
  wire rx_full = (rx_count == urlc_pkg::FIFO_DEPTH);
  wire tx_full = (tx_count == urlc_pkg::FIFO_DEPTH);
  wire pop_rd = rd_en & (haddr_i == urlc_pkg::ADDR_RX_POP) & ~rx_empty;
  wire flags_rd = rd_en & (haddr_i == urlc_pkg::ADDR_RX_FLAGS);
  wire wr_tx_data = wr_pend_q & (wr_addr_q == urlc_pkg::ADDR_TX_DATA);
  wire wr_tx_irq = wr_pend_q & (wr_addr_q == urlc_pkg::ADDR_TX_IRQ_EN);
  wire wr_rx_irq = wr_pend_q & (wr_addr_q == urlc_pkg::ADDR_RX_IRQ_EN);
  wire wr_limit = wr_pend_q & (wr_addr_q == urlc_pkg::ADDR_RX_IDLE_LIMIT);
  wire wr_setup = wr_pend_q & (wr_addr_q == urlc_pkg::ADDR_LINE_SETUP);
  wire push_tx = wr_tx_data & ~tx_full; // full fifo drops the write

  // popped byte, top bit masked in seven-bit mode
  wire [7:0] rx_head = rx_mem_q[rx_rp_q[3:0]];
  wire [7:0] rx_pop_val = cfg_q.char_length_sel ? {1'b0, rx_head[6:0]} : rx_head;

  // live status words
  wire cts_active = ~cts_sync_q[1];
  wire [7:0] rx_flags = {rx_sticky_q,
                         rx_count >= urlc_pkg::LVL_THREE_Q,
                         rx_count >= urlc_pkg::LVL_HALF,
                         rx_count >= urlc_pkg::LVL_QUARTER,
                         ~rx_empty};
  wire [5:0] tx_flags = {cts_active,
                         tx_count == 5'h00,
                         tx_count <= urlc_pkg::LVL_QUARTER,
                         tx_count <= urlc_pkg::LVL_HALF,
                         tx_count <= urlc_pkg::LVL_THREE_Q,
                         ~tx_full};

  // read mux, sampled at the address phase so data stands in the data phase
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr_i)
      urlc_pkg::ADDR_TX_STATUS: rdata_d = {26'h000_0000, tx_flags};
      urlc_pkg::ADDR_TX_IRQ_EN: rdata_d = {26'h000_0000, tx_irq_en_q};
      urlc_pkg::ADDR_RX_POP: rdata_d = {24'h00_0000, rx_empty ? 8'h00 : rx_pop_val};
      urlc_pkg::ADDR_RX_FLAGS: rdata_d = {24'h00_0000, rx_flags};
      urlc_pkg::ADDR_RX_IRQ_EN: rdata_d = {24'h00_0000, rx_irq_en_q};
      urlc_pkg::ADDR_RX_IDLE_LIMIT: rdata_d = {24'h00_0000, idle_limit_q};
      urlc_pkg::ADDR_LINE_SETUP: rdata_d = {26'h000_0000, cfg_q};
      default: rdata_d = 32'h0000_0000; // unmapped reads zero, OKAY
    endcase
  end

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend_q <= addr_phase & hwrite_i;
      if (addr_phase) begin
        wr_addr_q <= haddr_i;
      end
      if (rd_en) begin
        hrdata_o <= rdata_d;
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_irq_en_q <= urlc_pkg::RST_IRQ_EN;
      tx_irq_en_q <= 6'h00;
      idle_limit_q <= urlc_pkg::RST_IDLE_LIMIT;
      cfg_q <= urlc_pkg::RST_LINE_SETUP;
    end else begin
      if (wr_rx_irq) rx_irq_en_q <= hwdata_i[7:0];
      if (wr_tx_irq) tx_irq_en_q <= hwdata_i[5:0];
      if (wr_limit) idle_limit_q <= hwdata_i[7:0];
      if (wr_setup) cfg_q <= hwdata_i[5:0];
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_sync_q <= 2'b11;
      cts_sync_q <= 2'b11;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], rxd_i};
      cts_sync_q <= {cts_sync_q[0], cts_n_i};
    end
  end
  wire rxd_s = rxd_sync_q[1];

  // ---------------- receive engine ----------------
  wire [2:0] last_idx = cfg_q.char_length_sel ? 3'd6 : 3'd7;
  wire rx_bit_end = (rx_cnt_q == 8'h00);
  // even parity bit makes the total ones even
  wire [7:0] rx_data = cfg_q.char_length_sel ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
  logic exp_par;
  always_comb begin
    case (cfg_q.par_mode)
      urlc_pkg::PAR_EVEN: exp_par = ^rx_data;
      urlc_pkg::PAR_ODD: exp_par = ~^rx_data;
      urlc_pkg::PAR_SPACE: exp_par = 1'b0;
      urlc_pkg::PAR_MARK: exp_par = 1'b1;
      default: exp_par = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_q <= urlc_pkg::ST_IDLE;
      rx_cnt_q <= 8'h00;
      rx_idx_q <= 3'd0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_frame_bad_q <= 1'b0;
      rx_par_bad_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      rx_cnt_q <= rx_bit_end ? urlc_pkg::BIT_CYC - 8'h01 : rx_cnt_q - 8'h01;
      case (rx_st_q)
        urlc_pkg::ST_IDLE: begin
          rx_cnt_q <= urlc_pkg::HALF_BIT_CYC - 8'h01;
          if (!rxd_s) rx_st_q <= urlc_pkg::ST_START;
        end
        urlc_pkg::ST_START: begin
          if (rx_bit_end) begin
            rx_idx_q <= 3'd0;
            // glitch shorter than half a bit is not a start
            rx_st_q <= rxd_s ? urlc_pkg::ST_IDLE : urlc_pkg::ST_DATA;
          end
        end
        urlc_pkg::ST_DATA: begin
          if (rx_bit_end) begin
            rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
            rx_idx_q <= rx_idx_q + 3'd1;
            if (rx_idx_q == last_idx) begin
              rx_st_q <= cfg_q.par_en ? urlc_pkg::ST_PAR : urlc_pkg::ST_STOP;
            end
          end
        end
        urlc_pkg::ST_PAR: begin
          if (rx_bit_end) begin
            rx_par_q <= rxd_s;
            rx_st_q <= urlc_pkg::ST_STOP;
          end
        end
        urlc_pkg::ST_STOP: begin
          if (rx_bit_end) begin
            rx_done_q <= 1'b1;
            rx_frame_bad_q <= ~rxd_s;
            rx_par_bad_q <= cfg_q.par_en & (rx_par_q != exp_par);
            rx_st_q <= urlc_pkg::ST_IDLE;
          end
        end
        default: rx_st_q <= urlc_pkg::ST_IDLE;
      endcase
    end
  end

  // one char lands per done pulse unless the fifo is full; framing-bad chars are discarded
  wire rx_store = rx_done_q & ~rx_frame_bad_q;
  wire rx_push = rx_store & ~rx_full;
  wire rx_overrun = rx_store & rx_full;
  wire [7:0] rx_store_val = cfg_q.char_length_sel ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_wp_q <= 5'h00;
      rx_rp_q <= 5'h00;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 5'h01;
      if (pop_rd) rx_rp_q <= rx_rp_q + 5'h01;
    end
  end

  // storage has no reset, contents matter only behind the pointers
  always_ff @(posedge clk_i) begin
    if (rx_push) rx_mem_q[rx_wp_q[3:0]] <= rx_store_val;
    if (push_tx) tx_mem_q[tx_wp_q[3:0]] <= hwdata_i[7:0];
  end

  // idle counter in bit times; only runs while the receiver is idle
  wire tmo_reload = flags_rd | rx_done_q;
  wire tmo_tick = (tmo_pre_q == 8'h00);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_pre_q <= urlc_pkg::BIT_CYC - 8'h01;
      tmo_cnt_q <= urlc_pkg::RST_IDLE_LIMIT;
      tmo_hit_q <= 1'b0;
    end else begin
      tmo_pre_q <= tmo_tick ? urlc_pkg::BIT_CYC - 8'h01 : tmo_pre_q - 8'h01;
      tmo_hit_q <= 1'b0;
      if (tmo_reload) begin
        tmo_cnt_q <= idle_limit_q;
      end else if (tmo_tick && rx_st_q == urlc_pkg::ST_IDLE && tmo_cnt_q != 8'h00) begin
        tmo_cnt_q <= tmo_cnt_q - 8'h01;
        tmo_hit_q <= (tmo_cnt_q == 8'h01);
      end
    end
  end

  // sticky error flags: a set in the clearing cycle survives
  wire [3:0] sticky_set = {rx_done_q & rx_frame_bad_q, rx_overrun,
                           rx_done_q & rx_par_bad_q, tmo_hit_q};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sticky_q <= 4'h0;
    end else begin
      rx_sticky_q <= (rx_sticky_q & {4{~flags_rd}}) | sticky_set;
    end
  end

  // ---------------- transmit engine ----------------
  wire tx_may_send = ~cfg_q.cts_en | cts_active;
  wire tx_bit_end = (tx_cnt_q == 8'h00);
  wire [7:0] tx_head = tx_mem_q[tx_rp_q[3:0]];
  wire tx_start = (tx_st_q == urlc_pkg::ST_IDLE) & (tx_count != 5'h00) & tx_may_send;
  // software keeps bit 7 zero for seven-bit chars, so parity over all eight holds
  logic tx_par;
  always_comb begin
    case (cfg_q.par_mode)
      urlc_pkg::PAR_EVEN: tx_par = ^tx_sh_q;
      urlc_pkg::PAR_ODD: tx_par = ~^tx_sh_q;
      urlc_pkg::PAR_SPACE: tx_par = 1'b0;
      urlc_pkg::PAR_MARK: tx_par = 1'b1;
      default: tx_par = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_q <= urlc_pkg::ST_IDLE;
      tx_cnt_q <= 8'h00;
      tx_idx_q <= 3'd0;
      tx_sh_q <= 8'h00;
      tx_rp_q <= 5'h00;
      txd_o <= 1'b1;
    end else begin
      tx_cnt_q <= tx_bit_end ? urlc_pkg::BIT_CYC - 8'h01 : tx_cnt_q - 8'h01;
      case (tx_st_q)
        urlc_pkg::ST_IDLE: begin
          txd_o <= 1'b1;
          tx_cnt_q <= urlc_pkg::BIT_CYC - 8'h01;
          if (tx_start) begin
            tx_sh_q <= tx_head;
            tx_rp_q <= tx_rp_q + 5'h01;
            tx_idx_q <= 3'd0;
            txd_o <= 1'b0;
            tx_st_q <= urlc_pkg::ST_START;
          end
        end
        urlc_pkg::ST_START: begin
          if (tx_bit_end) begin
            txd_o <= tx_sh_q[0];
            tx_st_q <= urlc_pkg::ST_DATA;
          end
        end
        urlc_pkg::ST_DATA: begin
          if (tx_bit_end) begin
            tx_idx_q <= tx_idx_q + 3'd1;
            if (tx_idx_q == last_idx) begin
              txd_o <= cfg_q.par_en ? tx_par : 1'b1;
              tx_st_q <= cfg_q.par_en ? urlc_pkg::ST_PAR : urlc_pkg::ST_STOP;
            end else begin
              txd_o <= tx_sh_q[tx_idx_q + 3'd1];
            end
          end
        end
        urlc_pkg::ST_PAR: begin
          if (tx_bit_end) begin
            txd_o <= 1'b1;
            tx_st_q <= urlc_pkg::ST_STOP;
          end
        end
        urlc_pkg::ST_STOP: begin
          if (tx_bit_end) begin
            tx_st_q <= cfg_q.stop_two ? urlc_pkg::ST_STOP2 : urlc_pkg::ST_IDLE;
          end
        end
        urlc_pkg::ST_STOP2: begin
          if (tx_bit_end) tx_st_q <= urlc_pkg::ST_IDLE;
        end
        default: tx_st_q <= urlc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_wp_q <= 5'h00;
    end else if (push_tx) begin
      tx_wp_q <= tx_wp_q + 5'h01;
    end
  end

  // interrupt outputs, one cycle behind the flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= |(rx_flags & rx_irq_en_q);
      tx_irq_o <= |(tx_flags & tx_irq_en_q);
    end
  end

endmodule // urlc_top

//--- dv/urlc_peer.sv
`timescale 1ns/1ps
module urlc_peer (
  input wire logic clk_i,
  output logic line_o,
  input wire logic txd_i,
  output logic cts_n_o
);
  localparam int BIT = int'(urlc_pkg::BIT_CYC);
  logic line_q = 1'b1;
  logic cts_n_q = 1'b1;
  logic [7:0] cap;
  logic [7:0] got_q[$];
  // line idles high; the bench paces the sender through cts
  assign line_o = line_q;
  assign cts_n_o = cts_n_q;
  task automatic hold(input logic v, input int n);
    line_q <= v;
    repeat (n) @(posedge clk_i);
  endtask
  // stop is cut short so a bad stop cannot pose as a new start bit
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb,
    input logic stop);
    hold(1'b0, BIT);
    for (int i = 0; i < nb; i++) hold(d[i], BIT);
    if (pen) hold(pb, BIT);
    hold(stop, BIT * 3 / 4);
    hold(1'b1, BIT * 2);
  endtask
  // captures eight-bit characters mid-bit, lsb first
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      cap[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    got_q.push_back(cap);
  end
endmodule // urlc_peer

//--- dv/urlc_top_assertions.sv
`timescale 1ns/1ps
module urlc_top_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic cts_n_i,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o
);
  logic take, rd, wr_q;
  logic [31:0] wa_q;
  logic [7:0] rxe_q, lim_q;
  logic [5:0] txe_q, cfg_q;
  logic [15:0] low_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // taken transfers
  assign take = hsel_i && hready_i && htrans_i[1];
  assign rd = take && !hwrite_i;
  // shadows of written registers, committed with the data phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      wa_q <= '0;
      rxe_q <= 8'h00;
      lim_q <= 8'hFF;
      txe_q <= 6'h00;
      cfg_q <= 6'h00;
      low_q <= 16'h0000;
    end else begin
      wr_q <= take && hwrite_i;
      wa_q <= haddr_i;
      if (wr_q && wa_q == urlc_pkg::ADDR_RX_IRQ_EN) rxe_q <= hwdata_i[7:0];
      if (wr_q && wa_q == urlc_pkg::ADDR_RX_IDLE_LIMIT) lim_q <= hwdata_i[7:0];
      if (wr_q && wa_q == urlc_pkg::ADDR_TX_IRQ_EN) txe_q <= hwdata_i[5:0];
      if (wr_q && wa_q == urlc_pkg::ADDR_LINE_SETUP) cfg_q <= hwdata_i[5:0];
      // low runs are at most ten bit times (start, eight data, parity), far from wrapping
      low_q <= txd_o ? 16'h0000 : low_q + 16'h0001;
    end
  end
  rxen_read_a:
    assert property (rd && haddr_i == urlc_pkg::ADDR_RX_IRQ_EN |=> hrdata_o == {24'h0, rxe_q})
    else $error("rx enables read back wrong");
  limit_read_a:
    assert property (rd && haddr_i == urlc_pkg::ADDR_RX_IDLE_LIMIT |=> hrdata_o == {24'h0, lim_q})
    else $error("idle limit read back wrong");
  txen_read_a:
    assert property (rd && haddr_i == urlc_pkg::ADDR_TX_IRQ_EN |=> hrdata_o == {26'h0, txe_q})
    else $error("tx enables read back wrong");
  setup_read_a:
    assert property (rd && haddr_i == urlc_pkg::ADDR_LINE_SETUP |=> hrdata_o == {26'h0, cfg_q})
    else $error("line setup read back wrong");
  rx_irq_off_a:
    assert property ((rxe_q == 8'h00) [*2] |-> !rx_irq_o) else $error("rx irq while masked");
  tx_irq_off_a:
    assert property ((txe_q == 6'h00) [*2] |-> !tx_irq_o) else $error("tx irq while masked");
  cts_flag_a:
    assert property ((!cts_n_i) [*4] ##0 (rd && haddr_i == urlc_pkg::ADDR_TX_STATUS)
      |=> hrdata_o[5]) else $error("cts active flag missing");
  tx_bits_a:
    assert property ($rose(txd_o) |-> low_q % urlc_pkg::BIT_CYC == 0 && low_q != 16'h0000)
    else $error("tx low run not whole bit times");
  bus_okay_a:
    assert property (hreadyout_o && !hresp_o) else $error("bus answer not ready or not okay");
  cover property (rd && haddr_i == urlc_pkg::ADDR_RX_POP);
  cover property ($rose(rx_irq_o));
  cover property ($fell(txd_o));
endmodule // urlc_top_assertions
bind urlc_top urlc_top_assertions i_urlc_top_assertions (.clk_i, .rst_n_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hsize_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .rxd_i, .txd_o, .cts_n_i, .rx_irq_o, .tx_irq_o);

//--- dv/urlc_top_tb.sv
`timescale 1ns/1ps
module urlc_top_tb;
  localparam logic [31:0] FLG = urlc_pkg::ADDR_RX_FLAGS;
  localparam logic [31:0] POP = urlc_pkg::ADDR_RX_POP;
  localparam logic [31:0] SET = urlc_pkg::ADDR_LINE_SETUP;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam int BIT = int'(urlc_pkg::BIT_CYC);
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, m, r;
  logic hready, rxd, txd, cts_n, rx_irq, tx_irq, rd_ph, p;
  logic [7:0] b;
  logic [7:0] dq[$];
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] ra[4] = '{urlc_pkg::ADDR_RX_IRQ_EN, urlc_pkg::ADDR_RX_IDLE_LIMIT, SET,
    urlc_pkg::ADDR_TX_IRQ_EN};
  logic [31:0] rv[4] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000};
  logic [31:0] rm[4] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_003F, 32'h0000_003F};
  int err_count = 0;
  int tests_run = 0;
  int seed = 6;
  always #50 clk_i = ~clk_i;
  urlc_top i_urlc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .rxd_i(rxd), .txd_o(txd),
    .cts_n_i(cts_n), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));
  urlc_peer i_urlc_peer (.clk_i(clk_i), .line_o(rxd), .txd_i(txd), .cts_n_o(cts_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // single transfer: address phase, then idle with write data, each until hready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb,
    input logic stop);
    i_urlc_peer.send(d, nb, pen, pb, stop);
  endtask
  // read data is judged at the edge that closes its data phase
  always @(posedge clk_i) begin
    if (rd_ph === 1'b1) begin
      m = msk_q.pop_front();
      check(hrdata & m, exp_q.pop_front() & m);
    end
    rd_ph = hsel && htrans[1] && !hwrite && hready;
  end
  // a hang is cut off well past the longest expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (ra[i]) begin
      rd(ra[i], rv[i], ALL);
      r = $random(seed);
      wr(ra[i], r);
      rd(ra[i], r & rm[i], ALL);
      wr(ra[i], 32'h0000_0000);
    end
    rd(32'h4000_4030, 32'h0000_0000, ALL);
    send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    send(8'hC3, 8, 1'b0, 1'b0, 1'b1);
    rd(FLG, 32'h0000_0001, ALL);
    rd(POP, 32'h0000_005A, ALL);
    rd(POP, 32'h0000_00C3, ALL);
    rd(POP, 32'h0000_0000, ALL);
    wr(SET, 32'h0000_0001);
    send(8'hFF, 7, 1'b0, 1'b0, 1'b1);
    rd(POP, 32'h0000_007F, ALL);
    wr(SET, 32'h0000_0000);
    send(8'h81, 8, 1'b0, 1'b0, 1'b0);
    rd(FLG, 32'h0000_0080, 32'h0000_00F0);
    rd(FLG, 32'h0000_0000, 32'h0000_00F0);
    // every parity mode: a good character, then one with the bit flipped
    for (int md = 0; md < 4; md++) begin
      wr(SET, 32'(md * 4 + 2));
      b = 8'($random(seed));
      p = md[1] ? md[0] : (^b ^ md[0]);
      send(b, 8, 1'b1, p, 1'b1);
      rd(POP, {24'h0, b}, ALL);
      rd(FLG, 32'h0000_0000, 32'h0000_0020);
      send(b, 8, 1'b1, !p, 1'b1);
      rd(FLG, 32'h0000_0020, 32'h0000_0020);
      rd(POP, {24'h0, b}, ALL);
    end
    wr(SET, 32'h0000_0000);
    for (int i = 1; i <= 17; i++) begin
      b = 8'($random(seed));
      if (i < 17) dq.push_back(b);
      send(b, 8, 1'b0, 1'b0, 1'b1);
      if (i % 4 == 0) rd(FLG, 32'((1 << (i / 4 + 1)) - 1), 32'h0000_000F);
    end
    rd(FLG, 32'h0000_0040, 32'h0000_0040);
    wr(urlc_pkg::ADDR_RX_IRQ_EN, 32'h0000_0008);
    repeat (3) @(posedge clk_i);
    check({31'h0, rx_irq}, 32'h0000_0001);
    wr(urlc_pkg::ADDR_RX_IRQ_EN, 32'h0000_0040);
    repeat (3) @(posedge clk_i);
    check({31'h0, rx_irq}, 32'h0000_0000);
    wr(urlc_pkg::ADDR_RX_IRQ_EN, 32'h0000_0000);
    foreach (dq[i]) rd(POP, {24'h0, dq[i]}, ALL);
    wr(urlc_pkg::ADDR_RX_IDLE_LIMIT, 32'h0000_0002);
    rd(FLG, 32'h0000_0000, 32'h0000_0010);
    repeat (3 * BIT + 20) @(posedge clk_i);
    rd(FLG, 32'h0000_0010, 32'h0000_0010);
    rd(FLG, 32'h0000_0000, 32'h0000_0010);
    wr(urlc_pkg::ADDR_RX_IDLE_LIMIT, 32'h0000_0000);
    // cts held off: ignored without flow control, obeyed with it
    wr(urlc_pkg::ADDR_TX_DATA, 32'h0000_00A7);
    repeat (12 * BIT) @(posedge clk_i);
    check({24'h0, i_urlc_peer.got_q.pop_front()}, 32'h0000_00A7);
    wr(SET, 32'h0000_0020);
    rd(urlc_pkg::ADDR_TX_STATUS, 32'h0000_0000, 32'h0000_0020);
    wr(urlc_pkg::ADDR_TX_DATA, 32'h0000_003C);
    repeat (12 * BIT) @(posedge clk_i);
    check({31'h0, i_urlc_peer.got_q.size() == 0}, 32'h0000_0001);
    i_urlc_peer.cts_n_q <= 1'b0;
    // two synchroniser stages pass before the flag can show the new level
    repeat (3) @(posedge clk_i);
    rd(urlc_pkg::ADDR_TX_STATUS, 32'h0000_0020, 32'h0000_0020);
    repeat (12 * BIT) @(posedge clk_i);
    check({24'h0, i_urlc_peer.got_q.pop_front()}, 32'h0000_003C);
    // seven bits, even parity, two stops: the peer's eighth sample is the parity bit
    wr(SET, 32'h0000_0013);
    wr(urlc_pkg::ADDR_TX_DATA, 32'h0000_0034);
    repeat (12 * BIT) @(posedge clk_i);
    check({24'h0, i_urlc_peer.got_q.pop_front()}, 32'h0000_00B4);
    for (int i = 0; i < 5; i++) begin
      wr(urlc_pkg::ADDR_TX_IRQ_EN, 32'(1 << i));
      repeat (3) @(posedge clk_i);
      check({31'h0, tx_irq}, 32'h0000_0001);
    end
    wr(urlc_pkg::ADDR_TX_IRQ_EN, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    check({31'h0, tx_irq}, 32'h0000_0000);
    close_out();
  end
endmodule // urlc_top_tb
